/* File: hw/motion_report_registers.sv */
// motion report and frame statistics register block
`timescale 1ns/100ps
module motion_report_registers #(
  parameter int ACC_W = motion_report_pkg::ACC_WIDTH,
  parameter logic [7:0] SILICON_VERSION = motion_report_pkg::SILICON_VERSION_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic motion_valid,
  input wire logic signed [7:0] motion_dx,
  input wire logic signed [7:0] motion_dy,
  input wire logic counts_per_inch_flag,
  input wire logic sleep_state,
  input wire logic frame_done,
  input wire logic [motion_report_pkg::FEATURE_WIDTH-1:0] feature_count,
  input wire logic [motion_report_pkg::SUM_WIDTH-1:0] pixel_sum,
  input wire logic [motion_report_pkg::PIXEL_WIDTH-1:0] pixel_peak
);
  import motion_report_pkg::*;

  initial begin
    if (ACC_W <= 8 || ACC_W > 24) $error("ACC_W must be 9..24");
  end

  localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic signed [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};

  // =========================================
  // helpers
  function automatic logic signed [ACC_W-1:0] sat_add(input logic signed [ACC_W-1:0] a,
                                                       input logic signed [7:0] b,
                                                       output logic ovf);
    logic signed [ACC_W:0] s;
    s = {a[ACC_W-1], a} + (ACC_W+1)'(b);
    ovf = 1'b0;
    if (s > (ACC_W+1)'(ACC_MAX)) begin
      ovf = 1'b1;
      return ACC_MAX;
    end else if (s < (ACC_W+1)'(ACC_MIN)) begin
      ovf = 1'b1;
      return ACC_MIN;
    end
    return s[ACC_W-1:0];
  endfunction

  function automatic logic [7:0] clip8(input logic signed [ACC_W-1:0] a);
    if (a > ACC_W'(127)) return 8'h7f;
    if (a < -ACC_W'(128)) return 8'h80;
    return a[7:0];
  endfunction

  function automatic logic at_full(input logic signed [ACC_W-1:0] a);
    return (a == ACC_MAX) || (a == ACC_MIN);
  endfunction

  // =========================================
  // state
  logic signed [ACC_W-1:0] acc_x_q, acc_x_d, acc_y_q, acc_y_d;
  logic [7:0] frz_x_q, frz_x_d, frz_y_q, frz_y_d;
  logic ovf_q, ovf_d, mot_q, mot_d, disp_read_q, disp_read_d;
  logic [7:0] rd_data_d;
  logic [7:0] surface_q, brightness_q, brightest_q;
  logic [7:0] status_byte;
  logic ox, oy;
  logic signed [ACC_W-1:0] nx, ny;

  frame_stats_latch u_stats (
    .clk(clk),
    .rstn(rstn),
    .frame_done(frame_done),
    .feature_count(feature_count),
    .pixel_sum(pixel_sum),
    .pixel_peak(pixel_peak),
    .surface_q(surface_q),
    .brightness_q(brightness_q),
    .brightest_q(brightest_q)
  );

  // =========================================
  // motion accumulation and read side effects
  always_comb begin
    status_byte = 8'h00;
    status_byte[MOTION_BIT] = mot_q;
    status_byte[OVERFLOW_BIT] = ovf_q;
    status_byte[CPI_BIT] = counts_per_inch_flag;
    acc_x_d = acc_x_q;
    acc_y_d = acc_y_q;
    frz_x_d = frz_x_q;
    frz_y_d = frz_y_q;
    ovf_d = ovf_q;
    disp_read_d = disp_read_q;
    ox = 1'b0;
    oy = 1'b0;
    nx = acc_x_q;
    ny = acc_y_q;
    if (rd_strobe) begin
      if (rd_addr == ADDR_MOTION_STATUS) begin
        // freeze: move up to one report out of the accumulators
        frz_x_d = clip8(acc_x_q);
        frz_y_d = clip8(acc_y_q);
        nx = acc_x_q - ACC_W'(signed'(clip8(acc_x_q)));
        ny = acc_y_q - ACC_W'(signed'(clip8(acc_y_q)));
      end else if (rd_addr == ADDR_X_DISP) begin
        frz_x_d = RESET_BYTE;
        disp_read_d = 1'b1;
      end else if (rd_addr == ADDR_Y_DISP) begin
        frz_y_d = RESET_BYTE;
        disp_read_d = 1'b1;
      end
    end
    if (sleep_state) begin
      nx = '0;
      ny = '0;
    end else if (motion_valid) begin
      nx = sat_add(nx, motion_dx, ox);
      ny = sat_add(ny, motion_dy, oy);
    end
    acc_x_d = nx;
    acc_y_d = ny;
    if (disp_read_d && !at_full(nx) && !at_full(ny)) begin
      ovf_d = 1'b0;
      disp_read_d = 1'b0;
    end
    if (ox || oy) begin
      ovf_d = 1'b1;
      disp_read_d = 1'b0;
    end
    // pending while accumulated or frozen motion is unread
    mot_d = (nx != '0) || (ny != '0) || (frz_x_d != 8'h00) || (frz_y_d != 8'h00);
  end

  // =========================================
  // read data
  always_comb begin
    rd_data_d = rd_data;
    if (rd_strobe) begin
      if (rd_addr == ADDR_SILICON_VERSION) begin
        rd_data_d = SILICON_VERSION;
      end else if (rd_addr == ADDR_MOTION_STATUS) begin
        rd_data_d = status_byte;
      end else if (rd_addr == ADDR_X_DISP) begin
        rd_data_d = frz_x_q;
      end else if (rd_addr == ADDR_Y_DISP) begin
        rd_data_d = frz_y_q;
      end else if (rd_addr == ADDR_SURFACE_QUARTER) begin
        rd_data_d = surface_q;
      end else if (rd_addr == ADDR_BRIGHTNESS) begin
        rd_data_d = brightness_q;
      end else if (rd_addr == ADDR_BRIGHTEST) begin
        rd_data_d = brightest_q;
      end else begin
        rd_data_d = 8'h00;
      end
    end
  end

  // =========================================
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_x_q <= '0;
      acc_y_q <= '0;
      frz_x_q <= RESET_BYTE;
      frz_y_q <= RESET_BYTE;
      ovf_q <= 1'b0;
      mot_q <= 1'b0;
      disp_read_q <= 1'b0;
      rd_data <= RESET_BYTE;
    end else begin
      acc_x_q <= acc_x_d;
      acc_y_q <= acc_y_d;
      frz_x_q <= frz_x_d;
      frz_y_q <= frz_y_d;
      ovf_q <= ovf_d;
      mot_q <= mot_d;
      disp_read_q <= disp_read_d;
      rd_data <= rd_data_d;
    end
  end
endmodule

/* File: pkg/motion_report_pkg.sv */
// constants for the motion report and frame statistics registers
package motion_report_pkg;
  localparam logic [7:0] ADDR_SILICON_VERSION = 8'h01;
  localparam logic [7:0] ADDR_MOTION_STATUS = 8'h02;
  localparam logic [7:0] ADDR_X_DISP = 8'h03;
  localparam logic [7:0] ADDR_Y_DISP = 8'h04;
  localparam logic [7:0] ADDR_SURFACE_QUARTER = 8'h05;
  localparam logic [7:0] ADDR_BRIGHTNESS = 8'h06;
  localparam logic [7:0] ADDR_BRIGHTEST = 8'h07;
  localparam int MOTION_BIT = 7;
  localparam int OVERFLOW_BIT = 4;
  localparam int CPI_BIT = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int ACC_WIDTH = 12;
  localparam int PIXEL_WIDTH = 6;
  localparam int FEATURE_WIDTH = 10;
  localparam int SUM_WIDTH = 16;
  localparam logic [7:0] SURFACE_MAX = 8'ha9;
  localparam logic [7:0] BRIGHTNESS_MAX = 8'hdd;
  // arbitrary neutral value
  localparam logic [7:0] SILICON_VERSION_DEFAULT = 8'h5a;
endpackage

/* File: hw/frame_stats_latch.sv */
// per-frame statistics holding registers, updated together at frame end
`timescale 1ns/100ps
module frame_stats_latch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic frame_done,
  input wire logic [motion_report_pkg::FEATURE_WIDTH-1:0] feature_count,
  input wire logic [motion_report_pkg::SUM_WIDTH-1:0] pixel_sum,
  input wire logic [motion_report_pkg::PIXEL_WIDTH-1:0] pixel_peak,
  output logic [7:0] surface_q,
  output logic [7:0] brightness_q,
  output logic [7:0] brightest_q
);
  import motion_report_pkg::*;
  logic [7:0] surface_d, brightness_d, brightest_d;
  logic [7:0] feat_hi, sum_hi;

  // =========================================
  // next values
  always_comb begin
    feat_hi = feature_count[FEATURE_WIDTH-1 -: 8];
    sum_hi = pixel_sum[SUM_WIDTH-1 -: 8];
    surface_d = surface_q;
    brightness_d = brightness_q;
    brightest_d = brightest_q;
    if (frame_done) begin
      surface_d = (feat_hi > SURFACE_MAX) ? SURFACE_MAX : feat_hi;
      brightness_d = (sum_hi > BRIGHTNESS_MAX) ? BRIGHTNESS_MAX : sum_hi;
      brightest_d = {2'b00, pixel_peak};
    end
  end

  // =========================================
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      surface_q <= RESET_BYTE;
      brightness_q <= RESET_BYTE;
      brightest_q <= RESET_BYTE;
    end else begin
      surface_q <= surface_d;
      brightness_q <= brightness_d;
      brightest_q <= brightest_d;
    end
  end
endmodule

/* File: sim/mcu_model.sv */
// controller model issuing register reads
`timescale 1ns/100ps
module mcu_model (
  input wire logic clk,
  output logic rd_strobe,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial begin
    rd_strobe = 1'b0;
    rd_addr = 8'h00;
  end
  // =====
  // one read after g+1 idle cycles, address scrambled when idle
  task automatic rd(input logic [7:0] a, input int g, output logic [7:0] d);
    repeat (g + 1) @(posedge clk);
    #1 rd_strobe = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1 rd_strobe = 1'b0;
    rd_addr = ~a;
    d = rd_data;
  endtask
endmodule

/* File: sim/mrr_sva.sv */
// checker for the motion report registers
`timescale 1ns/100ps
module mrr_sva #(
  parameter logic [7:0] SILICON_VERSION = 8'h00
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic counts_per_inch_flag
);
  import motion_report_pkg::*;
  logic [7:0] h;
  assign h = (rd_strobe && rd_addr < 8'h08) ? 8'h01 << rd_addr[2:0] : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // =====
  // checks
  AST_VER: assert property (h[1] |=> rd_data == SILICON_VERSION)
    else $error("version wrong");
  AST_RSVD: assert property (h[2] |=> {rd_data[6:5], rd_data[3:1]} == 5'h00)
    else $error("status spare bits set");
  AST_CPI: assert property (h[2] |=> rd_data[CPI_BIT] == $past(counts_per_inch_flag))
    else $error("resolution bit wrong");
  AST_OVF: assert property (h[2] |=> rd_data[MOTION_BIT] || !rd_data[OVERFLOW_BIT])
    else $error("overflow without motion");
  AST_XCLR: assert property (h[3] ##2 h[3] |=> rd_data == 8'h00)
    else $error("x not cleared");
  AST_SURF: assert property (h[5] |=> rd_data <= SURFACE_MAX)
    else $error("surface too big");
  AST_BRT: assert property (h[6] |=> rd_data <= BRIGHTNESS_MAX)
    else $error("brightness too big");
  AST_HOLD: assert property (!rd_strobe |=> $stable(rd_data))
    else $error("read data moved");
  cover property (h[2] ##1 rd_data[OVERFLOW_BIT]);
  cover property (h[3] ##2 h[3]);
  cover property (h[7]);
endmodule
bind motion_report_registers mrr_sva #(.SILICON_VERSION(SILICON_VERSION)) chk_u (
  .clk(clk), .rstn(rstn), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
  .counts_per_inch_flag(counts_per_inch_flag));

/* File: sim/tb_motion_report_registers.sv */
// testbench for the motion report registers
`timescale 1ns/100ps
module tb_motion_report_registers;
  import motion_report_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, rd_strobe, mv = 1'b0, cpi = 1'b0, slp = 1'b0, fd = 1'b0;
  logic [7:0] rd_addr, rd_data, s, x, y, dx = 8'h00, dy = 8'h00;
  logic [9:0] fc = 10'h000;
  logic [15:0] ps = 16'h0000;
  logic [5:0] pk = 6'h00;
  int n_errors = 0, checks_done = 0;
  always #5 clk = ~clk;
  motion_report_registers #(.ACC_W(9)) dut_u (.clk(clk), .rstn(rstn), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr), .rd_data(rd_data), .motion_valid(mv), .motion_dx(dx), .motion_dy(dy),
    .counts_per_inch_flag(cpi), .sleep_state(slp), .frame_done(fd), .feature_count(fc),
    .pixel_sum(ps), .pixel_peak(pk));
  mcu_model mcu_u (.clk(clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data));
  // =====
  // helpers
  task automatic chk(input logic [7:0] e, g, input string n);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input logic [7:0] a, b);
    @(posedge clk);
    #1 mv = 1'b1;
    dx = a;
    dy = b;
    @(posedge clk);
    #1 mv = 1'b0;
  endtask
  // =====
  // scenarios
  task automatic t_reset;
    for (int a = 1; a < 9; a++) begin
      mcu_u.rd(8'(a), 0, s);
      chk(a == 1 ? SILICON_VERSION_DEFAULT : RESET_BYTE, s, "reset");
    end
  endtask
  task automatic t_motion;
    step(8'h05, 8'hfd);
    cpi = 1'b1;
    mcu_u.rd(ADDR_MOTION_STATUS, 0, s);
    chk(8'h81, s, "status");
    mcu_u.rd(ADDR_X_DISP, 0, x);
    chk(8'h05, x, "x");
    mcu_u.rd(ADDR_X_DISP, 0, x);
    chk(8'h00, x, "x again");
    mcu_u.rd(ADDR_Y_DISP, 0, y);
    chk(8'hfd, y, "y");
    step(8'h09, 8'h00);
    slp = 1'b1;
    @(posedge clk);
    #1 slp = 1'b0;
    mcu_u.rd(ADDR_MOTION_STATUS, 0, s);
    chk(8'h01, s, "sleep");
  endtask
  task automatic t_freeze;
    step(8'h0a, 8'h02);
    mcu_u.rd(ADDR_MOTION_STATUS, 0, s);
    step(8'h07, 8'h01);
    mcu_u.rd(ADDR_X_DISP, 0, x);
    chk(8'h0a, x, "frozen x");
    mcu_u.rd(ADDR_MOTION_STATUS, 0, s);
    mcu_u.rd(ADDR_X_DISP, 0, x);
    mcu_u.rd(ADDR_Y_DISP, 0, y);
    chk(8'h07, x, "new x");
    chk(8'h01, y, "new y");
  endtask
  task automatic t_ovf;
    logic [7:0] es [4] = '{8'h91, 8'h81, 8'h81, 8'h01};
    logic [7:0] ex [4] = '{8'h7f, 8'h7f, 8'h01, 8'h00};
    repeat (3) step(8'h7f, 8'h00);
    for (int i = 0; i < 4; i++) begin
      mcu_u.rd(ADDR_MOTION_STATUS, 3, s);
      mcu_u.rd(ADDR_X_DISP, 3, x);
      mcu_u.rd(ADDR_Y_DISP, 3, y);
      chk(es[i], s, "drain status");
      chk(ex[i], x, "drain x");
    end
  endtask
  task automatic t_frame(input logic [9:0] f, input logic [15:0] p, input logic [5:0] k,
    input logic [7:0] ef, ep);
    @(posedge clk);
    #1 fd = 1'b1;
    fc = f;
    ps = p;
    pk = k;
    @(posedge clk);
    #1 fd = 1'b0;
    mcu_u.rd(ADDR_BRIGHTEST, 0, s);
    chk({2'h0, k}, s, "peak");
    mcu_u.rd(ADDR_SURFACE_QUARTER, 0, s);
    chk(ef, s, "surface");
    mcu_u.rd(ADDR_BRIGHTNESS, 0, s);
    chk(ep, s, "brightness");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    t_reset();
    t_motion();
    t_freeze();
    t_ovf();
    t_frame(10'h3ff, 16'hffff, 6'h2a, 8'ha9, 8'hdd);
    t_frame(10'h0f3, 16'h1234, 6'h3f, 8'h3c, 8'h12);
    print_verdict();
  end
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
endmodule
